// ===== logic/fsirc_ctrl.sv
// Flash security, interrupt and reset-sequence controller.
// Assumes an array read port with one-cycle latency and synchronous inputs.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module fsirc_ctrl
   import fsirc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   output logic [22:0] arr_addr,
   output logic arr_rd,
   input wire logic [15:0] arr_data,
   input wire logic arr_dfault,
   input wire logic arr_sfault,
   output logic cpu_stall,
   output logic block0_invalid,
   input wire logic cmd_wr,
   output logic cmd_wr_taken,
   input wire logic launch,
   input wire logic launch_is_keyverify,
   input wire logic launch_is_verify_all,
   input wire logic [63:0] key_in,
   input wire logic op_done,
   input wire logic op_erased,
   input wire logic [1:0] cpu_mode,
   output logic cmd_allowed,
   output logic cmd_rejected,
   input wire logic cmd_complete_irq_en,
   input wire logic double_fault_irq_en,
   input wire logic single_fault_irq_en,
   input wire logic double_fault_flag,
   input wire logic single_fault_flag,
   input wire logic stop_req,
   output logic stop_ack,
   output logic wake_req,
   output logic cmd_irq,
   output logic err_irq,
   output logic cmd_complete_flag,
   output logic [1:0] controller_error_bits,
   output fsirc_cfg_t cfg
);
   typedef struct packed {
      fsirc_state_t st;
      logic [2:0] idx;
      logic [63:0] keys;
      logic key_bad;
      logic seq_err;
      logic ccf;
      logic [1:0] err;
      logic rej;
      fsirc_cfg_t cfg;
      logic [3:0] hold;
      logic keycmd_lock;
   } fsirc_regs_t;

   fsirc_regs_t r_q;
   fsirc_regs_t r_d;
   logic key_match;
   logic keys_legal;
   logic secured;
   logic dbg_err;

   assign secured = (r_q.cfg.lock_state_register.lock_state_bits != FSIRC_SEC_UNSECURE);

   always_comb begin
      keys_legal = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (key_in[16*i +: 16] == FSIRC_KEY_ZERO || key_in[16*i +: 16] == FSIRC_KEY_ONES) begin
            keys_legal = 1'b0;
         end
      end
      key_match = keys_legal && (key_in == r_q.keys);
   end

   // Secured parts in normal mode may still run key verify; others need unsecure or special mode
   always_comb begin
      cmd_allowed = 1'b0;
      if (launch_is_keyverify) begin
         cmd_allowed = !r_q.keycmd_lock &&
            (r_q.cfg.lock_state_register.backdoor_allow_field == FSIRC_BACKDOOR_ALLOW_FIELD_ON);
      end else begin
         cmd_allowed = !secured || (cpu_mode == FSIRC_MODE_SPECIAL);
      end
   end

   always_comb begin
      r_d = r_q;
      r_d.rej = 1'b0;
      dbg_err = 1'b0;
      case (r_q.st)
         FSIRC_HOLD: begin
            if (r_q.hold == FSIRC_HOLD_CYCLES) begin
               r_d.st = FSIRC_LOAD;
               r_d.idx = 3'h0;
            end else begin
               r_d.hold = r_q.hold + 4'h1;
            end
         end
         FSIRC_LOAD: begin
            // Index 1..4 capture keys, index 5 the security byte (each read is issued at the index before)
            if (r_q.idx != 3'h0) begin
               if (arr_dfault) begin
                  r_d.err = 2'h3;
                  r_d.seq_err = 1'b1;
               end
               if (r_q.idx <= 3'h4) begin
                  r_d.keys[16*(r_q.idx - 3'h1) +: 16] = arr_data;
               end else begin
                  r_d.cfg.lock_state_register = arr_data[7:0];
               end
            end
            if (r_q.idx == 3'h5) begin
               r_d.st = FSIRC_IDLE;
               r_d.ccf = 1'b1;
               r_d.cfg.program_array_guard_reg = FSIRC_PROT_DEFAULT;
               r_d.cfg.data_array_guard_reg = FSIRC_PROT_DEFAULT;
               r_d.cfg.option_register = FSIRC_OPT_DEFAULT;
               if (r_d.seq_err) begin
                  r_d.cfg.lock_state_register = FSIRC_SEC_DEFAULT;
               end
            end else begin
               r_d.idx = r_q.idx + 3'h1;
            end
         end
         FSIRC_IDLE: begin
            if (launch) begin
               if (!cmd_allowed) begin
                  r_d.rej = 1'b1;
               end else begin
                  r_d.ccf = 1'b0;
                  r_d.st = launch_is_keyverify ? FSIRC_KEYS : FSIRC_BUSY;
               end
            end
         end
         FSIRC_KEYS: begin
            if (key_match) begin
               r_d.cfg.lock_state_register.lock_state_bits = FSIRC_SEC_UNSECURE;
            end else begin
               r_d.keycmd_lock = 1'b1;
            end
            r_d.st = FSIRC_IDLE;
            r_d.ccf = 1'b1;
         end
         FSIRC_BUSY: begin
            if (op_done) begin
               if (launch_is_verify_all && op_erased && cpu_mode == FSIRC_MODE_SPECIAL) begin
                  r_d.cfg.lock_state_register.lock_state_bits = FSIRC_SEC_UNSECURE;
               end
               r_d.st = FSIRC_IDLE;
               r_d.ccf = 1'b1;
            end
         end
         default: begin
            r_d.st = FSIRC_HOLD;
            dbg_err = 1'b1;
         end
      endcase
   end

   // Reset loads HOLD and the default cfg and clears the rest, so any running command is dropped mid-way
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         r_q <= '{st: FSIRC_HOLD, cfg: '{FSIRC_PROT_DEFAULT, FSIRC_PROT_DEFAULT,
                  FSIRC_OPT_DEFAULT, FSIRC_SEC_DEFAULT}, default: '0};
      end else begin
         r_q <= r_d;
      end
   end

   // Array is only read during load; the byte is never written here
   always_comb begin
      arr_rd = (r_q.st == FSIRC_LOAD) && (r_q.idx < 3'h5);
      if (r_q.idx == 3'h4) begin
         arr_addr = FSIRC_SEC_BYTE_ADDR;
      end else begin
         arr_addr = FSIRC_KEY_BASE_ADDR + {19'h0, r_q.idx, 1'b0};
      end
   end

   assign cpu_stall = (r_q.st == FSIRC_HOLD);
   assign cmd_wr_taken = cmd_wr && r_q.ccf && (r_q.st == FSIRC_IDLE);
   assign block0_invalid = (r_q.st == FSIRC_KEYS);
   assign cmd_rejected = r_q.rej;
   assign cmd_complete_flag = r_q.ccf;
   assign controller_error_bits = r_q.err;
   assign cfg = r_q.cfg;
   // Stop is held off while a command runs; ack is combinational
   assign stop_ack = stop_req && r_q.ccf;

   fsirc_irq_gate u_cmd (
      .flag(r_q.ccf),
      .en(cmd_complete_irq_en),
      .req(cmd_irq)
   );

   logic dreq;
   logic sreq;
   fsirc_irq_gate u_dbl (
      .flag(double_fault_flag),
      .en(double_fault_irq_en),
      .req(dreq)
   );
   fsirc_irq_gate u_sgl (
      .flag(single_fault_flag),
      .en(single_fault_irq_en),
      .req(sreq)
   );
   assign err_irq = dreq | sreq;
   assign wake_req = cmd_irq;

   a_cmd_irq_level: assert property (@(posedge core_clk) disable iff (!rstn)
      cmd_irq == (cmd_complete_flag && cmd_complete_irq_en)) else $error("cmd irq wrong");
   a_err_irq_level: assert property (@(posedge core_clk) disable iff (!rstn)
      err_irq == ((double_fault_flag && double_fault_irq_en) ||
                  (single_fault_flag && single_fault_irq_en))) else $error("err irq wrong");
   a_wake_follow: assert property (@(posedge core_clk) disable iff (!rstn)
      wake_req == cmd_irq) else $error("wake wrong");
   a_stop_hold: assert property (@(posedge core_clk) disable iff (!rstn)
      (stop_req && !cmd_complete_flag) |-> !stop_ack) else $error("stop early");
   a_key_unsec: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_KEYS && key_match) |=> cfg.lock_state_register.lock_state_bits == 2'h2)
      else $error("no unsecure");
   a_key_lock: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_KEYS && !key_match) |=> r_q.keycmd_lock) else $error("no lock");
   a_block0_inv: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(block0_invalid) |=> !block0_invalid) else $error("block0 long");
   a_ccf_seq: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_HOLD || r_q.st == FSIRC_LOAD) |-> !cmd_complete_flag)
      else $error("ccf during seq");
   a_wr_ignored: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st != FSIRC_IDLE) |-> !cmd_wr_taken) else $error("write taken");
   a_stall_end: assert property (@(posedge core_clk) disable iff (!rstn)
      $fell(cpu_stall) |-> r_q.st == FSIRC_LOAD ##6 cmd_complete_flag)
      else $error("seq timing");
   a_state_legal: assert property (@(posedge core_clk) disable iff (!rstn)
      !dbg_err) else $error("illegal state");
   // Double fault seen on any sequence read must leave the part secured
   a_seq_err_lock: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_LOAD && r_q.idx == 3'h5 && (r_q.seq_err || arr_dfault)) |=>
      cfg.lock_state_register == FSIRC_SEC_DEFAULT) else $error("no fallback");
   a_dfault_err: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_LOAD && r_q.idx != 3'h0 && arr_dfault) |=>
      controller_error_bits == 2'h3) else $error("err bits missing");
   a_guard_default: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_LOAD && r_q.idx == 3'h5) |=>
      (cfg.program_array_guard_reg == FSIRC_PROT_DEFAULT &&
       cfg.data_array_guard_reg == FSIRC_PROT_DEFAULT &&
       cfg.option_register == FSIRC_OPT_DEFAULT)) else $error("init wrong");
   a_sec_read: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_LOAD && r_q.idx == 3'h4) |->
      (arr_rd && arr_addr == FSIRC_SEC_BYTE_ADDR)) else $error("sec byte read");
   // Key verify must not touch guards, option or stored keys
   a_guard_keep: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_KEYS) |=> ($stable(cfg.program_array_guard_reg) &&
      $stable(cfg.data_array_guard_reg) && $stable(cfg.option_register)))
      else $error("guard changed");
   a_keys_keep: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_KEYS) |=> $stable(r_q.keys)) else $error("keys changed");
   a_bad_key_lock: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_KEYS && !keys_legal) |=> r_q.keycmd_lock)
      else $error("illegal key took");
   a_block0_key: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_KEYS) |-> block0_invalid) else $error("block0 readable");
   a_locked_reject: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_IDLE && launch && launch_is_keyverify && r_q.keycmd_lock) |=>
      cmd_rejected) else $error("locked key cmd ran");
   a_backdoor_allow_field_reject: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_IDLE && launch && launch_is_keyverify &&
       cfg.lock_state_register.backdoor_allow_field != FSIRC_BACKDOOR_ALLOW_FIELD_ON) |=>
      cmd_rejected) else $error("key cmd not gated");
   a_secure_reject: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_IDLE && launch && !launch_is_keyverify && secured &&
       cpu_mode != FSIRC_MODE_SPECIAL) |=> cmd_rejected) else $error("secure cmd ran");
   a_erase_unsec: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_BUSY && op_done && launch_is_verify_all && op_erased &&
       cpu_mode == FSIRC_MODE_SPECIAL) |=>
      cfg.lock_state_register.lock_state_bits == FSIRC_SEC_UNSECURE)
      else $error("erase no unsecure");
   a_done_sets: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_BUSY && op_done) |=> cmd_complete_flag) else $error("no done");
   a_launch_clears: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_IDLE && launch && cmd_allowed) |=> !cmd_complete_flag)
      else $error("flag not cleared");
   a_stop_grant: assert property (@(posedge core_clk) disable iff (!rstn)
      (stop_req && cmd_complete_flag) |-> stop_ack) else $error("stop not granted");
   a_wr_accept: assert property (@(posedge core_clk) disable iff (!rstn)
      (r_q.st == FSIRC_IDLE && cmd_complete_flag && cmd_wr) |-> cmd_wr_taken)
      else $error("write dropped");
   a_irq_drop: assert property (@(posedge core_clk) disable iff (!rstn)
      !cmd_complete_irq_en |-> !cmd_irq) else $error("irq not dropped");

   c_seq_done: cover property (@(posedge core_clk) disable iff (!rstn) $rose(cmd_complete_flag));
   c_key_ok: cover property (@(posedge core_clk) disable iff (!rstn)
      r_q.st == FSIRC_KEYS && key_match);
   c_reject: cover property (@(posedge core_clk) disable iff (!rstn) cmd_rejected);
   c_stop: cover property (@(posedge core_clk) disable iff (!rstn) stop_req && !stop_ack);
   c_key_lock: cover property (@(posedge core_clk) disable iff (!rstn)
      r_q.st == FSIRC_KEYS && !key_match);
endmodule

// ===== inc/fsirc_pkg.sv
// Package for the flash security, interrupt and reset-sequence controller.
// Assumes one core clock and an array read port outside this block.
package fsirc_pkg;
   localparam logic [22:0] FSIRC_SEC_BYTE_ADDR = 23'h7FFF0F;
   localparam logic [22:0] FSIRC_KEY_BASE_ADDR = 23'h7FFF00;
   localparam logic [2:0] FSIRC_KEY_LAST_IDX = 3'h3;
   localparam logic [1:0] FSIRC_SEC_UNSECURE = 2'h2;
   localparam logic [1:0] FSIRC_SEC_SECURED = 2'h3;
   localparam logic [1:0] FSIRC_BACKDOOR_ALLOW_FIELD_ON = 2'h2;
   localparam logic [7:0] FSIRC_SEC_DEFAULT = 8'hFF;
   localparam logic [7:0] FSIRC_OPT_DEFAULT = 8'hFF;
   localparam logic [7:0] FSIRC_PROT_DEFAULT = 8'h00;
   localparam logic [15:0] FSIRC_KEY_ZERO = 16'h0000;
   localparam logic [15:0] FSIRC_KEY_ONES = 16'hFFFF;
   localparam logic [3:0] FSIRC_HOLD_CYCLES = 4'h4;
   localparam logic [1:0] FSIRC_MODE_NORMAL = 2'h0;
   localparam logic [1:0] FSIRC_MODE_SPECIAL = 2'h1;

   typedef enum logic [4:0] {
      FSIRC_HOLD = 5'b00001,
      FSIRC_LOAD = 5'b00010,
      FSIRC_IDLE = 5'b00100,
      FSIRC_BUSY = 5'b01000,
      FSIRC_KEYS = 5'b10000
   } fsirc_state_t;

   typedef struct packed {
      logic [1:0] lock_state_bits;
      logic [1:0] backdoor_allow_field;
      logic [3:0] rsvd;
   } fsirc_sec_t;

   typedef struct packed {
      logic [7:0] program_array_guard_reg;
      logic [7:0] data_array_guard_reg;
      logic [7:0] option_register;
      fsirc_sec_t lock_state_register;
   } fsirc_cfg_t;
endpackage

// ===== logic/fsirc_irq_gate.sv
// Flag and enable gate for one interrupt source.
// Assumes flags and enables are registered in the same clock domain.
`timescale 1ns/1ps
module fsirc_irq_gate (
   input wire logic flag,
   input wire logic en,
   output logic req
);
   assign req = flag & en;
endmodule

// ===== dv/fsirc_array_model.sv
// Array read port model holding the stored keys and the security byte.
// Assumes read data one cycle after the read strobe and address.
`timescale 1ns/1ps
module fsirc_array_model (
   input wire logic core_clk,
   input wire logic [22:0] arr_addr,
   input wire logic arr_rd,
   input wire logic [63:0] keys,
   input wire logic [7:0] sec_byte,
   input wire logic inject_df,
   output logic [15:0] arr_data,
   output logic arr_dfault
);
   import fsirc_pkg::*;
   initial arr_data = 16'h0000;
   initial arr_dfault = 1'b0;
   always @(posedge core_clk) begin
      arr_dfault <= arr_rd & inject_df;
      if (!arr_rd)
         arr_data <= ~arr_data; // Idle bus never keeps its last value
      else if (arr_addr == FSIRC_SEC_BYTE_ADDR)
         arr_data <= {sec_byte, sec_byte};
      else
         arr_data <= keys[{arr_addr[2:1], 4'h0} +: 16];
   end
endmodule

// ===== dv/tb_flash_security_irq_reset_ctrl.sv
// Self-checking bench for the flash security and reset-sequence controller.
// Assumes the array model answers reads; the bench acts as CPU and debug host.
`timescale 1ns/1ps
module tb_flash_security_irq_reset_ctrl;
   import fsirc_pkg::*;
   logic core_clk = 0, rstn = 0, launch = 0, launch_is_keyverify = 0, launch_is_verify_all = 0;
   logic op_done = 0, op_erased = 0, cmd_wr = 0, stop_req = 0, inject_df = 0;
   logic cmd_complete_irq_en = 0, double_fault_irq_en = 0, single_fault_irq_en = 0;
   logic double_fault_flag = 0, single_fault_flag = 0;
   logic [1:0] cpu_mode = 0;
   logic [63:0] key_in = 0, keys = 0, good;
   logic [7:0] sec_byte = 0;
   logic [22:0] arr_addr;
   logic [15:0] arr_data;
   logic arr_rd, arr_dfault, cpu_stall, block0_invalid, cmd_wr_taken, cmd_rejected;
   logic stop_ack, wake_req, cmd_irq, err_irq, cmd_complete_flag;
   logic [1:0] controller_error_bits;
   fsirc_cfg_t cfg;
   int n_fail = 0, n_checks = 0, cycles = 0, m_lock, m_err;
   int m_keys[$];
   bit m_blocked;
   integer seed;
   fsirc_ctrl fsirc_ctrl_inst (.core_clk(core_clk), .rstn(rstn), .arr_addr(arr_addr),
      .arr_rd(arr_rd), .arr_data(arr_data), .arr_dfault(arr_dfault), .arr_sfault(1'b0),
      .cpu_stall(cpu_stall), .block0_invalid(block0_invalid), .cmd_wr(cmd_wr),
      .cmd_wr_taken(cmd_wr_taken), .launch(launch), .launch_is_keyverify(launch_is_keyverify),
      .launch_is_verify_all(launch_is_verify_all), .key_in(key_in), .op_done(op_done),
      .op_erased(op_erased), .cpu_mode(cpu_mode), .cmd_allowed(), .cmd_rejected(cmd_rejected),
      .cmd_complete_irq_en(cmd_complete_irq_en), .double_fault_irq_en(double_fault_irq_en),
      .single_fault_irq_en(single_fault_irq_en), .double_fault_flag(double_fault_flag),
      .single_fault_flag(single_fault_flag), .stop_req(stop_req), .stop_ack(stop_ack),
      .wake_req(wake_req), .cmd_irq(cmd_irq), .err_irq(err_irq),
      .cmd_complete_flag(cmd_complete_flag), .controller_error_bits(controller_error_bits),
      .cfg(cfg));
   fsirc_array_model fsirc_array_model_inst (.core_clk(core_clk), .arr_addr(arr_addr),
      .arr_rd(arr_rd), .keys(keys), .sec_byte(sec_byte), .inject_df(inject_df),
      .arr_data(arr_data), .arr_dfault(arr_dfault));
   always #12.5 core_clk = ~core_clk;
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic do_reset(input logic [7:0] sb, input logic [63:0] k, input logic df);
      bit reads;
      @(posedge core_clk);
      rstn <= 0;
      sec_byte <= sb;
      keys <= k;
      inject_df <= df;
      cmd_wr <= 1;
      launch_is_verify_all <= 0;
      repeat (8) @(posedge core_clk);
      chk(cmd_complete_flag, 0);
      chk(cpu_stall, 1);
      chk(cfg, 32'h0000FFFF);
      rstn <= 1;
      m_lock = df ? 8'hFF : sb;
      m_err = df ? 3 : 0;
      m_blocked = 0;
      m_keys = {k[15:0], k[31:16], k[47:32], k[63:48]};
      @(posedge core_clk);
      #1 chk(cpu_stall, 1);
      reads = 0;
      for (int n = 0; n < 40 && cmd_complete_flag !== 1'b1; n++) begin
         chk(cmd_wr_taken, 0);
         if (cpu_stall === 1'b0) reads = 1;
         @(posedge core_clk);
         #1;
      end
      chk(reads, 1);
      chk(cmd_complete_flag, 1);
      chk(cmd_wr_taken, 1);
      chk(cfg, {24'h0000FF, m_lock[7:0]});
      chk(controller_error_bits, m_err);
      @(posedge core_clk);
      cmd_wr <= 0;
   endtask
   task automatic key_verify(input logic [63:0] k);
      bit ok, match;
      ok = m_lock[5:4] == 2 && !m_blocked;
      match = 1;
      foreach (m_keys[i])
         if (m_keys[i] != k[16*i +: 16] || k[16*i +: 16] inside {16'h0000, 16'hFFFF}) match = 0;
      @(posedge core_clk);
      launch <= 1;
      launch_is_keyverify <= 1;
      key_in <= k;
      @(posedge core_clk);
      launch <= 0;
      #1 chk(block0_invalid, ok);
      chk(cmd_rejected, !ok);
      if (ok) chk(cmd_complete_flag, 0);
      if (ok && match) m_lock[7:6] = 2;
      if (ok && !match) m_blocked = 1;
      @(posedge core_clk);
      #1 chk(cmd_complete_flag, 1);
      chk(cfg, {24'h0000FF, m_lock[7:0]});
      @(posedge core_clk);
      launch_is_keyverify <= 0;
   endtask
   task automatic verify_all(input logic [1:0] mode, input logic erased, input int dly);
      bit ok;
      ok = mode == FSIRC_MODE_SPECIAL || m_lock[7:6] == 2;
      @(posedge core_clk);
      cpu_mode <= mode;
      launch <= 1;
      launch_is_verify_all <= 1;
      stop_req <= 1;
      cmd_complete_irq_en <= 1;
      @(posedge core_clk);
      launch <= 0;
      #1 chk(cmd_rejected, !ok);
      if (ok) begin
         repeat (dly) begin
            chk({cmd_complete_flag, stop_ack, wake_req}, 0);
            @(posedge core_clk);
         end
         op_done <= 1;
         op_erased <= erased;
         @(posedge core_clk);
         op_done <= 0;
         for (int n = 0; n < 10 && cmd_complete_flag !== 1'b1; n++) @(posedge core_clk);
         #1 chk({cmd_complete_flag, stop_ack, wake_req}, 3'h7);
         if (mode == FSIRC_MODE_SPECIAL && erased) m_lock[7:6] = 2;
         chk(cfg, {24'h0000FF, m_lock[7:0]});
      end
      @(posedge core_clk);
      launch_is_verify_all <= 0;
      stop_req <= 0;
   endtask
   task automatic irq_mix();
      logic [4:0] r;
      for (int i = 0; i < 32; i++) begin
         r = $random(seed);
         @(posedge core_clk);
         {cmd_complete_irq_en, double_fault_irq_en, single_fault_irq_en} <= r[4:2];
         {double_fault_flag, single_fault_flag} <= r[1:0];
         #1 chk({cmd_irq, wake_req}, {r[4], r[4]});
         chk(err_irq, r[3] & r[1] | r[2] & r[0]);
      end
   endtask
   initial begin
      seed = 32'hFCC9;
      good = {$random(seed), $random(seed)};
      good = good & 64'h7FFE7FFE7FFE7FFE | 64'h0001000100010001;
      do_reset(8'hEF, good, 0);
      irq_mix();
      $display("test irq done");
      key_verify(good ^ 64'h10);
      key_verify(good);
      verify_all(FSIRC_MODE_NORMAL, 1, 3);
      do_reset(8'hEF, good, 0);
      key_verify(good);
      verify_all(FSIRC_MODE_NORMAL, 1, 3);
      do_reset(8'hEF, good, 0);
      $display("test backdoor done");
      do_reset(8'hFF, good, 0);
      key_verify(good);
      do_reset(8'hEF, 64'h0, 0);
      key_verify(64'h0);
      do_reset(8'hEF, good, 1);
      $display("test refusals done");
      do_reset(8'hEF, good, 0);
      verify_all(FSIRC_MODE_SPECIAL, 0, 2);
      verify_all(FSIRC_MODE_SPECIAL, 1, 5);
      @(posedge core_clk);
      launch <= 1;
      launch_is_verify_all <= 1;
      @(posedge core_clk);
      launch <= 0;
      repeat (2) @(posedge core_clk);
      do_reset(8'hEF, good, 0);
      $display("test erase and abort done");
      conclude();
   end
endmodule
